// file: design/agrc_pkg.sv
// Constants and types shared by the automatic gain recovery control block.
package agrc_pkg;

  // ***************************************************
  // Clock and sample rate
  // ***************************************************
  localparam longint CLK_HZ = 200000000;
  localparam longint FS_HZ = 48000;
  // Sample period in clock cycles, rounded to the nearest cycle.
  localparam int SAMPLE_DIV_DEF = int'((CLK_HZ + FS_HZ / 2) / FS_HZ);

  // ***************************************************
  // Register indexes (byte address is four times the index)
  // ***************************************************
  localparam logic [5:0] IDX_LIM_CTRL = 6'h09;
  localparam logic [5:0] IDX_GAIN_L = 6'h0a;
  localparam logic [5:0] IDX_GAIN_R = 6'h0b;
  localparam logic [5:0] IDX_TIMING_STEP = 6'h0c;
  localparam logic [5:0] IDX_REF_GAIN = 6'h0d;
  localparam logic [5:0] IDX_ZC_CTRL = 6'h0e;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int LIM_EN_BIT = 7;
  localparam int RCV_EN_BIT = 6;
  localparam int LVL_LSB = 3;
  localparam int WAIT_LSB = 2;
  localparam int ZC_EN_BIT = 0;
  localparam int NRTM_LSB = 1;
  localparam logic [7:0] LIM_CTRL_RST = 8'h18;
  localparam logic [3:0] TIMING_STEP_RST = 4'h8;
  localparam logic [6:0] REF_GAIN_RST = 7'h30;
  localparam logic [6:0] GAIN_RST = 7'h30;
  localparam logic [2:0] ZC_CTRL_RST = 3'h1;

  // ***************************************************
  // Sample counts
  // ***************************************************
  localparam int WAIT_BASE = 512;
  localparam int NRTM_BASE = 256;

  // Level thresholds on a 15-bit magnitude: -10, -8, -6, -4, -2 dBFS.
  localparam logic [14:0] LVL_TH [0:4] = '{
    15'h287a, 15'h32f5, 15'h4027, 15'h50c3, 15'h65ac};

  // ***************************************************
  // Operating states
  // ***************************************************
  typedef enum logic [1:0] {ST_MANUAL, ST_LIMIT, ST_WAIT} agrc_state_t;

endpackage

// file: design/agrc_top.sv
// Automatic gain recovery control with its APB register file.
//
// What this block does
// RULE1 - Recovery starts after limiter completion, flag one, limiter and recovery enabled.
// RULE2 - Recovery raises one common gain code for both channels toward the ceiling.
// RULE3 - Either channel over detection level aborts recovery into limiting at once.
// RULE4 - Timing register: wait bits 3:2, step bits 1:0, upper zero, reset 08.
// RULE5 - Wait codes select 512, 1024, 2048 or 4096 sample periods.
// RULE6 - Without limiter events one recovery step per elapsed waiting period.
// RULE7 - Waiting counter clears while input exceeds the selected reset level.
// RULE8 - Waiting counter runs once input falls below the reset level.
// RULE9 - A longer zero crossing timeout paces steps instead of the wait.
// RULE10 - Step codes add 1, 2, 3 or 4 gain increments; reset is one.
// RULE11 - Zero cross off applies on sample tick; on, at crossing or timeout.
// RULE12 - A step passing the ceiling loads the ceiling and stops rising.
// RULE13 - First step one full period after limiting; then one per period.
// RULE14 - Next waiting period counts while a change awaits zero crossing.
// RULE15 - Limiter during pending crossing starts from smaller channel gain, both set.
// RULE16 - Limiter while idle between steps starts from current gain.
// RULE17 - Power-down low resets timing register and blocks its writes.
// RULE18 - Ceiling register holds 7-bit code, bit 7 zero, reset 30h.
// RULE19 - Ceiling uses the input gain encoding, 68h maximum, 00h mute.
// RULE20 - Software keeps both gains at or below the ceiling before full auto.
// RULE21 - Power-down low resets ceiling bits and blocks their writes.
// RULE22 - Level select picks reset band from -8/-10 dB up to -2/-4 dB.
// RULE23 - Completion flag in both gain registers sets when limiting finishes.
// RULE24 - Gain already at ceiling stays put while waiting periods keep counting.
`timescale 1ns/1ps
module agrc_top
  import agrc_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Power-down pin, low active, asynchronous
  input wire logic power_down_pin_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Channel peak magnitudes and zero crossings
  input wire logic [14:0] peak_l_i,
  input wire logic [14:0] peak_r_i,
  input wire logic zc_l_i,
  input wire logic zc_r_i,
  // Limiter hand-over
  input wire logic limiter_gain_load_i,
  input wire logic [6:0] limiter_gain_i,
  input wire logic limit_done_i,
  output logic limiter_start_o,
  output logic [6:0] limiter_start_gain_o,
  output logic limiter_enable_o,
  output logic [1:0] limiter_level_select_o,
  // Gain and status
  output logic [6:0] left_input_gain_o,
  output logic [6:0] right_input_gain_o,
  output logic gain_op_done_flag_o,
  output logic recovering_o
);

  // ***************************************************
  // Registers and wires
  // ***************************************************
  logic pd_meta_ff, pd_ff;
  logic [15:0] div_ff;
  logic fs_en_ff;
  logic pready_ff, pslverr_ff, limiter_start_ff;
  logic [31:0] prdata_ff;
  logic [7:0] lim_ctrl_ff;
  logic [3:0] timing_step_ff;
  logic [6:0] ref_gain_ff;
  logic [2:0] zc_ctrl_ff;
  logic [6:0] gain_l_ff, gain_r_ff, start_gain_ff, tgt_ff;
  logic done_ff, pend_l_ff, pend_r_ff;
  logic [12:0] wcnt_ff, tcnt_ff;
  agrc_state_t state_ff;
  logic over_det, above_rst, wr_acc, step_due, zc_on, timeout_hit;
  logic [2:0] lvl_idx;
  logic [12:0] wait_len, nrtm_len, period;
  logic [7:0] sum;
  logic [6:0] nxt_tgt, min_gain, base_gain;
  logic [5:0] idx;

  assign idx = paddr_i[7:2];
  assign wr_acc = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;
  assign zc_on = zc_ctrl_ff[ZC_EN_BIT];

  // ***************************************************
  // Pin synchroniser and sample tick
  // ***************************************************

  // Power-down pin is asynchronous, so two flops before use.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pd_meta_ff <= 1'b0;
      pd_ff <= 1'b0;
    end else begin
      pd_meta_ff <= power_down_pin_n_i;
      pd_ff <= pd_meta_ff;
    end
  end

  // Divider making a one-cycle pulse per sample period.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_ff <= 16'h0000;
      fs_en_ff <= 1'b0;
    end else if (div_ff == 16'(SAMPLE_DIV - 1)) begin
      div_ff <= 16'h0000;
      fs_en_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      fs_en_ff <= 1'b0;
    end
  end

  // ***************************************************
  // Level detection and step arithmetic
  // ***************************************************

  // RULE22 - reset band select
  assign lvl_idx = {1'b0, lim_ctrl_ff[LVL_LSB +: 2]};
  // RULE3 - detection level compare
  assign over_det = (peak_l_i >= LVL_TH[lvl_idx + 3'h1]) |
                    (peak_r_i >= LVL_TH[lvl_idx + 3'h1]);
  // RULE7 - waiting reset level compare
  assign above_rst = (peak_l_i >= LVL_TH[lvl_idx]) | (peak_r_i >= LVL_TH[lvl_idx]);

  // RULE5 - waiting period length
  assign wait_len = 13'(WAIT_BASE) << timing_step_ff[WAIT_LSB +: 2];
  assign nrtm_len = 13'(NRTM_BASE) << zc_ctrl_ff[NRTM_LSB +: 2];
  // RULE9 - timeout paces when longer
  assign period = (zc_on && nrtm_len > wait_len) ? nrtm_len : wait_len;

  // RULE6 - one step per period
  // RULE8 - counting only below reset level
  assign step_due = (state_ff == ST_WAIT) & fs_en_ff & ~above_rst &
                    (wcnt_ff == period - 13'h0001);
  assign timeout_hit = fs_en_ff & (tcnt_ff == nrtm_len - 13'h0001);

  // A step that meets its own timeout builds on the target landing now, or a step is lost.
  assign base_gain = pend_l_ff ? tgt_ff : gain_l_ff;
  // RULE10 - step size code plus one
  assign sum = {1'b0, base_gain} + {6'h00, timing_step_ff[1:0]} + 8'h01;
  // RULE12 - clamp at ceiling
  // RULE24 - hold when already there
  always_comb begin
    if (base_gain >= ref_gain_ff) begin
      nxt_tgt = base_gain;
    end else if (sum > {1'b0, ref_gain_ff}) begin
      nxt_tgt = ref_gain_ff;
    end else begin
      nxt_tgt = sum[6:0];
    end
  end
  assign min_gain = (gain_l_ff < gain_r_ff) ? gain_l_ff : gain_r_ff;

  // ***************************************************
  // Operating mode
  // ***************************************************

  // Limiting, recovery and manual hand-over; flag tracks limiter completion.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_MANUAL;
      done_ff <= 1'b1;
      limiter_start_ff <= 1'b0;
      start_gain_ff <= GAIN_RST;
    end else begin
      limiter_start_ff <= 1'b0;
      if (!pd_ff || !lim_ctrl_ff[LIM_EN_BIT]) begin
        state_ff <= ST_MANUAL;
        done_ff <= 1'b1;
      end else begin
        unique case (state_ff)
          ST_MANUAL: begin
            if (fs_en_ff && over_det) begin
              state_ff <= ST_LIMIT;
              done_ff <= 1'b0;
              limiter_start_ff <= 1'b1;
              start_gain_ff <= gain_l_ff;
            end
          end
          ST_LIMIT: begin
            // RULE23 - flag on completion
            if (limit_done_i) begin
              done_ff <= 1'b1;
              // RULE1 - recovery needs both enables
              state_ff <= lim_ctrl_ff[RCV_EN_BIT] ? ST_WAIT : ST_MANUAL;
            end
          end
          ST_WAIT: begin
            if (!lim_ctrl_ff[RCV_EN_BIT]) begin
              state_ff <= ST_MANUAL;
            end else if (fs_en_ff && over_det) begin
              // RULE3 - abandon recovery now
              state_ff <= ST_LIMIT;
              done_ff <= 1'b0;
              limiter_start_ff <= 1'b1;
              // RULE15 - smaller channel when pending
              // RULE16 - else current gain
              start_gain_ff <= (pend_l_ff || pend_r_ff) ? min_gain : gain_l_ff;
            end
          end
        endcase
      end
    end
  end

  // ***************************************************
  // Waiting counter and zero crossing timeout
  // ***************************************************

  // RULE13 - cleared on entry, full period first
  // RULE14 - keeps counting while a change is pending
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wcnt_ff <= 13'h0000;
    end else if (state_ff != ST_WAIT) begin
      wcnt_ff <= 13'h0000;
    end else if (fs_en_ff) begin
      // RULE7 - clear above reset level
      wcnt_ff <= (above_rst || step_due) ? 13'h0000 : wcnt_ff + 13'h0001;
    end
  end

  // Timeout counter runs only while a change waits for a crossing.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tcnt_ff <= 13'h0000;
    end else if (step_due || !(pend_l_ff || pend_r_ff)) begin
      tcnt_ff <= 13'h0000;
    end else if (fs_en_ff) begin
      tcnt_ff <= tcnt_ff + 13'h0001;
    end
  end

  // ***************************************************
  // Gain registers and pending changes
  // ***************************************************

  // Pending flags per channel; a limiter event cancels them.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_l_ff <= 1'b0;
      pend_r_ff <= 1'b0;
      tgt_ff <= GAIN_RST;
    end else if (state_ff != ST_WAIT || (fs_en_ff && over_det)) begin
      pend_l_ff <= 1'b0;
      pend_r_ff <= 1'b0;
    end else if (step_due && zc_on) begin
      // RULE11 - wait for crossing or timeout
      pend_l_ff <= 1'b1;
      pend_r_ff <= 1'b1;
      tgt_ff <= nxt_tgt;
    end else begin
      if (zc_l_i || timeout_hit) begin
        pend_l_ff <= 1'b0;
      end
      if (zc_r_i || timeout_hit) begin
        pend_r_ff <= 1'b0;
      end
    end
  end

  // Both channel gains; priority: power-down, limiter, recovery, software.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gain_l_ff <= GAIN_RST;
      gain_r_ff <= GAIN_RST;
    end else if (!pd_ff) begin
      gain_l_ff <= GAIN_RST;
      gain_r_ff <= GAIN_RST;
    end else if (state_ff == ST_LIMIT) begin
      if (limiter_gain_load_i) begin
        gain_l_ff <= limiter_gain_i;
        gain_r_ff <= limiter_gain_i;
      end
    end else if (state_ff == ST_WAIT) begin
      if (fs_en_ff && over_det && (pend_l_ff || pend_r_ff)) begin
        // RULE15 - both set to smaller gain
        gain_l_ff <= min_gain;
        gain_r_ff <= min_gain;
      end else if (step_due && !zc_on) begin
        // RULE2 - common gain to both
        // RULE11 - applied on sample tick
        gain_l_ff <= nxt_tgt;
        gain_r_ff <= nxt_tgt;
      end else begin
        if (pend_l_ff && (zc_l_i || timeout_hit)) begin
          gain_l_ff <= tgt_ff;
        end
        if (pend_r_ff && (zc_r_i || timeout_hit)) begin
          gain_r_ff <= tgt_ff;
        end
      end
    end else if (wr_acc && idx == IDX_GAIN_L) begin
      gain_l_ff <= pwdata_i[6:0];
    end else if (wr_acc && idx == IDX_GAIN_R) begin
      gain_r_ff <= pwdata_i[6:0];
    end
  end

  // ***************************************************
  // Control registers
  // ***************************************************

  // RULE17 - timing register reset and locked
  // RULE21 - ceiling reset and locked
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim_ctrl_ff <= LIM_CTRL_RST;
      timing_step_ff <= TIMING_STEP_RST;
      ref_gain_ff <= REF_GAIN_RST;
      zc_ctrl_ff <= ZC_CTRL_RST;
    end else if (!pd_ff) begin
      lim_ctrl_ff <= LIM_CTRL_RST;
      timing_step_ff <= TIMING_STEP_RST;
      ref_gain_ff <= REF_GAIN_RST;
      zc_ctrl_ff <= ZC_CTRL_RST;
    end else if (wr_acc) begin
      if (idx == IDX_LIM_CTRL) begin
        lim_ctrl_ff <= pwdata_i[7:0] & 8'hdf;
      end
      // RULE4 - four writable bits
      if (idx == IDX_TIMING_STEP) begin
        timing_step_ff <= pwdata_i[3:0];
      end
      // RULE18 - seven-bit ceiling
      // RULE19 - gain code encoding
      if (idx == IDX_REF_GAIN) begin
        ref_gain_ff <= pwdata_i[6:0];
      end
      if (idx == IDX_ZC_CTRL) begin
        zc_ctrl_ff <= pwdata_i[2:0];
      end
    end
  end

  // ***************************************************
  // APB slave
  // ***************************************************

  // One wait state: pready rises one cycle into the access phase.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      unique case (idx)
        IDX_LIM_CTRL: prdata_ff[7:0] <= lim_ctrl_ff;
        // RULE23 - flag in both gain registers
        IDX_GAIN_L: prdata_ff[7:0] <= {done_ff, gain_l_ff};
        IDX_GAIN_R: prdata_ff[7:0] <= {done_ff, gain_r_ff};
        IDX_TIMING_STEP: prdata_ff[3:0] <= timing_step_ff;
        IDX_REF_GAIN: prdata_ff[6:0] <= ref_gain_ff;
        IDX_ZC_CTRL: prdata_ff[2:0] <= zc_ctrl_ff;
        default: pslverr_ff <= 1'b1;
      endcase
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ***************************************************
  // Outputs, all straight from flops except recovering_o, decoded from state_ff
  // ***************************************************
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign limiter_start_o = limiter_start_ff;
  assign limiter_start_gain_o = start_gain_ff;
  assign limiter_enable_o = lim_ctrl_ff[LIM_EN_BIT];
  assign limiter_level_select_o = lim_ctrl_ff[LVL_LSB +: 2];
  assign left_input_gain_o = gain_l_ff;
  assign right_input_gain_o = gain_r_ff;
  assign gain_op_done_flag_o = done_ff;
  assign recovering_o = (state_ff == ST_WAIT);

endmodule

// file: testbench/agrc_top_sva.sv
// Port-level assertions for the gain recovery control block.
`timescale 1ns/1ps
module agrc_top_chk
  import agrc_pkg::*;
#(
  parameter int SAMPLE_DIV = 4
) (
  // Clock and reset
  input logic clk_i,
  input logic arst_n_i,
  // Watched inputs
  input logic power_down_pin_n_i,
  input logic [14:0] peak_l_i,
  input logic [14:0] peak_r_i,
  input logic limit_done_i,
  // Watched outputs
  input logic limiter_start_o,
  input logic [6:0] limiter_start_gain_o,
  input logic limiter_enable_o,
  input logic [1:0] limiter_level_select_o,
  input logic [6:0] left_input_gain_o,
  input logic [6:0] right_input_gain_o,
  input logic gain_op_done_flag_o,
  input logic recovering_o
);
  // ********
  // Helpers
  // ********
  logic over;
  logic [2:0] det_idx;
  logic [6:0] low_gain;
  logic [6:0] left_q_ff;
  int over_cnt_ff;
  int gap_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Detection sits one band above the waiting counter reset band.
  assign det_idx = {1'b0, limiter_level_select_o} + 3'd1;
  assign over = (peak_l_i >= LVL_TH[det_idx]) || (peak_r_i >= LVL_TH[det_idx]);
  assign low_gain = (left_input_gain_o < right_input_gain_o) ?
    left_input_gain_o : right_input_gain_o;
  // Cycles in recovery with a loud input; a tick must end this quickly.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      over_cnt_ff <= 0;
    end else begin
      over_cnt_ff <= (recovering_o && over) ? over_cnt_ff + 1 : 0;
    end
  end
  // Cycles since the last gain change inside recovery.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_ff <= 0;
      left_q_ff <= GAIN_RST;
    end else begin
      gap_ff <= (!recovering_o || left_input_gain_o != left_q_ff) ? 0 : gap_ff + 1;
      left_q_ff <= left_input_gain_o;
    end
  end
  // ********
  // Checks
  // ********
  // entry after completion.
  chk_rec_entry: assert property (
    $rose(recovering_o) |-> $past(limit_done_i) && limiter_enable_o)
    else $error("recovery entered without completion");
  chk_rec_flag: assert property (
    recovering_o |-> gain_op_done_flag_o && $past(limiter_enable_o))
    else $error("recovery while flag or enable low");
  chk_abort_bound: assert property (
    over_cnt_ff <= SAMPLE_DIV + 2)
    else $error("recovery not abandoned on loud input");
  chk_start_flag: assert property (
    limiter_start_o |-> !gain_op_done_flag_o && !recovering_o)
    else $error("flag or recovery still set at limiter start");
  chk_done_flag: assert property (
    limit_done_i && !gain_op_done_flag_o |=> gain_op_done_flag_o)
    else $error("flag not set after completion");
  chk_step_size: assert property (
    recovering_o && $past(recovering_o) && left_input_gain_o != $past(left_input_gain_o)
    |-> left_input_gain_o > $past(left_input_gain_o) &&
    {1'b0, left_input_gain_o} <= {1'b0, $past(left_input_gain_o)} + 8'd4)
    else $error("recovery step out of range");
  chk_step_gap: assert property (
    recovering_o && $past(recovering_o) && left_input_gain_o != $past(left_input_gain_o)
    |-> gap_ff >= 510 * SAMPLE_DIV)
    else $error("recovery steps too close");
  chk_start_gain: assert property (
    limiter_start_o |-> limiter_start_gain_o == low_gain)
    else $error("limiter start gain not the lower code");
  chk_pd_hold: assert property (
    !power_down_pin_n_i [*4] |-> left_input_gain_o == GAIN_RST &&
    right_input_gain_o == GAIN_RST)
    else $error("gains not reset in power down");
  // Main scenarios reached.
  cov_enter: cover property ($rose(recovering_o));
  cov_abort: cover property (recovering_o ##1 limiter_start_o);
  cov_pending: cover property (recovering_o && left_input_gain_o != right_input_gain_o);
endmodule

bind agrc_top agrc_top_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .power_down_pin_n_i(power_down_pin_n_i),
  .peak_l_i(peak_l_i), .peak_r_i(peak_r_i), .limit_done_i(limit_done_i),
  .limiter_start_o(limiter_start_o), .limiter_start_gain_o(limiter_start_gain_o),
  .limiter_enable_o(limiter_enable_o), .limiter_level_select_o(limiter_level_select_o),
  .left_input_gain_o(left_input_gain_o), .right_input_gain_o(right_input_gain_o),
  .gain_op_done_flag_o(gain_op_done_flag_o), .recovering_o(recovering_o)
);

// file: testbench/tb_agrc_top.sv
// Self-checking bench for the automatic gain recovery control block.
`timescale 1ns/1ps
module tb_agrc_top;
  import agrc_pkg::*;
  // A short sample period keeps the waiting periods affordable.
  localparam int D = 4;
  logic clk_i, rec, flag, err, pready, pslverr, lstart, len;
  logic arst_n_i = 1'b0, pd_n = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic zl = 1'b0, zr = 1'b0, gload = 1'b0, done = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [14:0] pkl = 15'h0000, pkr = 15'h0000;
  logic [6:0] lgain = 7'h00, sgain, gl, gr;
  logic [1:0] lsel;
  int errors = 0, tests_run = 0, t, k;

  agrc_top #(.SAMPLE_DIV(D)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .power_down_pin_n_i(pd_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .peak_l_i(pkl), .peak_r_i(pkr), .zc_l_i(zl), .zc_r_i(zr),
    .limiter_gain_load_i(gload), .limiter_gain_i(lgain), .limit_done_i(done),
    .limiter_start_o(lstart), .limiter_start_gain_o(sgain), .limiter_enable_o(len),
    .limiter_level_select_o(lsel), .left_input_gain_o(gl), .right_input_gain_o(gr),
    .gain_op_done_flag_o(flag), .recovering_o(rec)
  );

  // Clock at 200 MHz.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ********
  // Tasks
  // ********
  // Report one mismatch.
  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  // Compare a value of the design.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("got %0h expected %0h", got, exp));
  endtask
  // Compare a delay in cycles against a window.
  task automatic chk_win(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) fail($sformatf("delay %0d not in %0d..%0d", got, lo, hi));
  endtask
  // One APB transfer; the request stands until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) fail("no ready");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Loud right input until the limiter is called, then hand back gain g.
  task automatic limit(input logic [6:0] g, input logic [6:0] s);
    t = 0;
    pkr <= 15'h7000;
    do @(posedge clk_i); while (lstart !== 1'b1 && ++t < 4 * D);
    chk_win(t, 0, D + 1);
    chk(sgain, s);
    chk(flag, 1'b0);
    pkr <= 15'h0000;
    gload <= 1'b1;
    lgain <= g;
    @(posedge clk_i);
    gload <= 1'b0;
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
  endtask
  // Time the next gain change; p is the period in samples.
  task automatic step(input int p, input logic [6:0] g);
    logic [6:0] g0;
    g0 = gl;
    t = 0;
    do @(posedge clk_i); while (gl === g0 && ++t < 5000 * D);
    chk_win(t, (p - 1) * D, (p + 1) * D + 2);
    chk(gl, g);
    chk(gr, g);
  endtask
  // Print counts and verdict, then stop.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(8'h30, 32'h08);
    rdchk(8'h34, 32'h30);
    rdchk(8'h28, 32'hb0);
    apb(1'b0, 8'hfc, 32'h0);
    chk(err, 1'b1);
    wr(8'h30, 32'hff);
    rdchk(8'h30, 32'h0f);
    wr(8'h34, 32'hff);
    rdchk(8'h34, 32'h7f);
    pd_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(8'h34, 32'h11);
    rdchk(8'h34, 32'h30);
    rdchk(8'h30, 32'h08);
    pd_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Full automatic mode, zero crossing off, top detection level.
    wr(8'h38, 32'h00);
    wr(8'h34, 32'h68);
    wr(8'h24, 32'hd8);
    chk(len, 1'b1);
    chk(lsel, 2'h3);
    for (k = 0; k < 4; k++) begin
      wr(8'h30, 32'(5 * k));
      limit(7'h20, (k == 0) ? 7'h30 : 7'h20 + k[6:0]);
      step(512 << k, 7'h21 + k[6:0]);
    end
    chk(flag, 1'b1);
    // A level inside the reset band restarts the wait.
    wr(8'h30, 32'h00);
    limit(7'h40, 7'h24);
    repeat (200 * D) @(posedge clk_i);
    pkl <= 15'h5800;
    repeat (20 * D) @(posedge clk_i);
    pkl <= 15'h0000;
    step(512, 7'h41);
    // Clamp at the ceiling, then hold there.
    wr(8'h34, 32'h42);
    wr(8'h30, 32'h03);
    limit(7'h3f, 7'h41);
    step(512, 7'h42);
    repeat (1100 * D) @(posedge clk_i);
    chk(gl, 7'h42);
    chk(rec, 1'b1);
    // Zero crossing mode: each channel waits for its own crossing.
    wr(8'h34, 32'h68);
    wr(8'h38, 32'h01);
    limit(7'h10, 7'h42);
    repeat (514 * D) @(posedge clk_i);
    chk(gl, 7'h10);
    zl <= 1'b1;
    @(posedge clk_i);
    zl <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(gl, 7'h14);
    chk(gr, 7'h10);
    // A timeout longer than the wait paces the step, applied at timeout.
    wr(8'h38, 32'h05);
    limit(7'h08, 7'h10);
    step(2048, 7'h0c);
    end_sim();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #400000;
    fail("watchdog expired");
    end_sim();
  end
endmodule
